// ==== rtl/dcc_sync.sv ====
// Multi-stage synchroniser for the comparator decisions
`timescale 1ns/10ps
`include "dcc_defs.svh"
module dcc_sync #(
  parameter int STAGES = `DCC_SYNC_STAGES
) (
  input wire logic clk,
  input wire logic rstn,
  dcc_cmp_if.sync cmp
);
  import dcc_pkg::*;

  typedef struct packed {
    logic [STAGES-1:0][1:0] chain;
  } dcc_sync_st_t;

  dcc_sync_st_t st_q;
  dcc_sync_st_t st_d;

  generate
    if (STAGES < 2) begin : g_bad
      $error("dcc_sync needs at least two stages");
    end
  endgenerate

  // First stage feeds only the next stage
  always_comb begin
    st_d = st_q;
    st_d.chain[0] = cmp.raw;
    for (int i = 1; i < STAGES; i++) begin
      st_d.chain[i] = st_q.chain[i-1];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign cmp.synced = st_q.chain[STAGES-1];
endmodule

// ==== rtl/dcc_top.sv ====
// Control and status logic for a dual comparator
//
// Contract
// - Uninverted status bit is 1 when positive input exceeds negative.
// - Per-comparator invert bit reverses the reported output polarity.
// - Status bits 7:6 are read-only, ignore writes, reset to zero.
// - In mode 110 the switch bit picks alternate negative input pins.
// - Three-bit mode field selects one of eight operating modes.
// - Mode 110 routes the internal reference to both positive inputs.
// - Mode 111 powers both comparators off.
// - Reset clears control, mode 000 all analog, comparators off.
// - Flag sets when any output differs from its latched value.
// - Mismatch keeps setting flag; control access relatches outputs.
// - Writing 0 clears the flag, writing 1 sets it.
// - Request reaches core only with all three enables set.
// - A change coinciding with a control read may miss the flag.
// - Routed pins carry unsynchronised outputs, gated by direction bits.
// - Active comparator interrupt wakes from sleep, register kept.
// - Port reads give 0 for every pin in analog use.
//
// Implementation choices: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
`include "dcc_defs.svh"
module dcc_top #(
  parameter int SYNC_STAGES = `DCC_SYNC_STAGES
) (
  input wire logic clk,
  input wire logic rstn,
  input dcc_pkg::dcc_addr_t addr,
  input dcc_pkg::dcc_data_t wdata,
  input wire logic wr,
  input wire logic rd,
  output dcc_pkg::dcc_data_t rdata,
  input dcc_pkg::dcc_cmp_t cmp_decision,
  input dcc_pkg::dcc_cmp_t port_f_direction,
  input dcc_pkg::dcc_pins_t pin_level,
  input wire logic sleep_active,
  output dcc_pkg::dcc_mode_t comparator_mode_field,
  output dcc_pkg::dcc_cmp_t cmp_power_on,
  output logic vref_to_positive,
  output logic negative_input_switch,
  output dcc_pkg::dcc_cmp_t pin_out,
  output dcc_pkg::dcc_cmp_t pin_oe,
  output logic irq_request,
  output logic wake_request
);
  import dcc_pkg::*;

  dcc_state_t st_q;
  dcc_state_t st_d;

  dcc_cmp_if cmp_bus ();

  dcc_mode_t mode;
  dcc_cmp_t invert;
  dcc_cmp_t reported;
  dcc_cmp_t out_now;
  dcc_pins_t analog_mask;
  logic in_switch;
  logic powered;
  logic route_en;
  logic ctrl_hit;
  logic irq_hit;
  logic port_hit;
  logic ctrl_access;
  logic mismatch;
  logic set_event;

  generate
    if (SYNC_STAGES < 2) begin : g_bad
      $error("dcc_top needs at least two synchroniser stages");
    end
  endgenerate

  // Raw decisions enter through the synchroniser
  assign cmp_bus.raw = cmp_decision;

  dcc_sync #(
    .STAGES(SYNC_STAGES)
  ) u_sync (
    .clk(clk),
    .rstn(rstn),
    .cmp(cmp_bus)
  );

  // Field decode of the control register
  assign mode = st_q.ctrl[`DCC_CTRL_MODE_HI:`DCC_CTRL_MODE_LO];
  assign in_switch = st_q.ctrl[`DCC_CTRL_SWITCH_BIT];
  assign invert[0] = st_q.ctrl[`DCC_CTRL_INV1_BIT];
  assign invert[1] = st_q.ctrl[`DCC_CTRL_INV2_BIT];

  // Modes 000 and 111 keep the comparators unpowered
  assign powered = (mode != `DCC_MODE_RESET) &&
                   (mode != `DCC_MODE_OFF);

  assign route_en = (mode == `DCC_MODE_ROUTE_A) ||
                    (mode == `DCC_MODE_ROUTE_B);

  // Per-comparator polarity and pin routing
  genvar gi;
  generate
    for (gi = 0; gi < `DCC_NUM_CMP; gi++) begin : g_cmp
      // Positive above negative gives 1 unless inverted
      assign reported[gi] = cmp_bus.synced[gi] ^
                            invert[gi];
      assign out_now[gi] = powered & reported[gi];
      // Raw path on purpose: no synchroniser delay on the pin
      assign pin_out[gi] = route_en &
                           (cmp_decision[gi] ^ invert[gi]);
      assign pin_oe[gi] = route_en & ~port_f_direction[gi];
    end
  endgenerate

  // Pins in analog use per mode
  always_comb begin
    unique case (mode)
      3'h0: analog_mask = `DCC_MASK_ALL;
      3'h1: analog_mask = `DCC_MASK_ALL;
      3'h2: analog_mask = `DCC_MASK_ALL;
      3'h3: analog_mask = `DCC_MASK_ROUTED;
      3'h4: analog_mask = `DCC_MASK_ROUTED;
      3'h5: analog_mask = `DCC_MASK_ROUTED;
      3'h6: analog_mask = in_switch ? `DCC_MASK_VREF_ALT
                              : `DCC_MASK_VREF_PRI;
      3'h7: analog_mask = `DCC_MASK_NONE;
    endcase
  end

  // Address decode
  assign ctrl_hit = (addr == `DCC_OFF_CTRL);
  assign irq_hit = (addr == `DCC_OFF_IRQ);
  assign port_hit = (addr == `DCC_OFF_PORT);
  assign ctrl_access = (wr || rd) && ctrl_hit;

  assign mismatch = (out_now != st_q.latch);

  // Access cycle relatches and swallows any change in the same cycle
  assign set_event = mismatch && !ctrl_access;

  always_comb begin
    st_d = st_q;
    st_d.rdata = '0;
    st_d.outs = out_now;

    // Any control access ends the mismatch
    if (ctrl_access) begin
      st_d.latch = out_now;
    end

    if (wr && ctrl_hit) begin
      // Status bits stay out of reach of writes
      st_d.ctrl = 6'(wdata & `DCC_CTRL_WR_MASK);
    end

    if (wr && irq_hit) begin
      st_d.flag = wdata[`DCC_IRQ_FLAG_BIT];
      st_d.irq_en = wdata[`DCC_IRQ_IE_BIT];
      st_d.periph_en = wdata[`DCC_IRQ_PIE_BIT];
      st_d.global_en = wdata[`DCC_IRQ_GLOBAL_BIT];
    end

    // Hardware set beats a software clear
    if (set_event) begin
      st_d.flag = 1'b1;
    end

    if (rd) begin
      if (ctrl_hit) begin
        st_d.rdata = {st_q.outs[1], st_q.outs[0],
                      st_q.ctrl};
      end else if (irq_hit) begin
        st_d.rdata[`DCC_IRQ_FLAG_BIT] = st_q.flag;
        st_d.rdata[`DCC_IRQ_IE_BIT] = st_q.irq_en;
        st_d.rdata[`DCC_IRQ_PIE_BIT] = st_q.periph_en;
        st_d.rdata[`DCC_IRQ_GLOBAL_BIT] = st_q.global_en;
      end else if (port_hit) begin
        // Analog pins read low whatever their voltage
        st_d.rdata = {2'h0, pin_level & ~analog_mask};
      end
    end
  end

  // Sleep touches nothing here, so register contents survive it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign rdata = st_q.rdata;
  assign comparator_mode_field = mode;
  assign cmp_power_on = {powered, powered};
  assign vref_to_positive = (mode == `DCC_MODE_VREF);
  assign negative_input_switch = (mode == `DCC_MODE_VREF) &&
                                 in_switch;

  // Flag sets regardless, request needs all three enables
  assign irq_request = st_q.flag && st_q.irq_en &&
                       st_q.periph_en && st_q.global_en;
  assign wake_request = sleep_active && irq_request;
endmodule

// ==== shared/dcc_cmp_if.sv ====
// Raw and synchronised comparator decisions
`timescale 1ns/10ps
interface dcc_cmp_if;
  logic [1:0] raw;
  logic [1:0] synced;
  modport src (output raw, input synced);
  modport sync (input raw, output synced);
endinterface

// ==== shared/dcc_defs.svh ====
// Register map, field positions, reset values and mode codes
`ifndef DCC_DEFS_SVH
`define DCC_DEFS_SVH

`define DCC_ADDR_W 4
`define DCC_DATA_W 8
`define DCC_NUM_CMP 2
`define DCC_NUM_PINS 6

`define DCC_OFF_CTRL 4'h0
`define DCC_OFF_IRQ 4'h1
`define DCC_OFF_PORT 4'h2

`define DCC_CTRL_OUT2_BIT 7
`define DCC_CTRL_OUT1_BIT 6
`define DCC_CTRL_INV2_BIT 5
`define DCC_CTRL_INV1_BIT 4
`define DCC_CTRL_SWITCH_BIT 3
`define DCC_CTRL_MODE_HI 2
`define DCC_CTRL_MODE_LO 0
`define DCC_CTRL_WR_MASK 8'h3f
`define DCC_CTRL_RESET 8'h00

`define DCC_IRQ_FLAG_BIT 0
`define DCC_IRQ_IE_BIT 1
`define DCC_IRQ_PIE_BIT 2
`define DCC_IRQ_GLOBAL_BIT 3
`define DCC_IRQ_RESET 8'h00

`define DCC_MODE_RESET 3'h0
`define DCC_MODE_ROUTE_A 3'h3
`define DCC_MODE_ROUTE_B 3'h5
`define DCC_MODE_VREF 3'h6
`define DCC_MODE_OFF 3'h7

`define DCC_MASK_ALL 6'h3f
`define DCC_MASK_ROUTED 6'h3c
`define DCC_MASK_VREF_PRI 6'h2a
`define DCC_MASK_VREF_ALT 6'h14
`define DCC_MASK_NONE 6'h00

`define DCC_SYNC_STAGES 2

`endif

// ==== shared/dcc_pkg.sv ====
// Types shared by the comparator control logic
`include "dcc_defs.svh"
package dcc_pkg;
  typedef logic [`DCC_ADDR_W-1:0] dcc_addr_t;
  typedef logic [`DCC_DATA_W-1:0] dcc_data_t;
  typedef logic [`DCC_NUM_CMP-1:0] dcc_cmp_t;
  typedef logic [`DCC_NUM_PINS-1:0] dcc_pins_t;
  typedef logic [2:0] dcc_mode_t;

  typedef struct packed {
    logic [5:0] ctrl;
    dcc_cmp_t outs;
    dcc_cmp_t latch;
    logic flag;
    logic irq_en;
    logic periph_en;
    logic global_en;
    dcc_data_t rdata;
  } dcc_state_t;
endpackage

// ==== verif/dcc_cmp_model.sv ====
// Comparator decisions and pin levels seen by the block
`timescale 1ns/10ps
module dcc_cmp_model (
  input wire logic clk,
  input dcc_pkg::dcc_cmp_t want,
  input wire logic slow,
  input dcc_pkg::dcc_pins_t pins,
  output dcc_pkg::dcc_cmp_t cmp_decision,
  output dcc_pkg::dcc_pins_t pin_level
);
  logic [2:0] n_q = 3'h0;
  initial cmp_decision = 2'b00;
  assign pin_level = pins;
  // Slow response mimics settling; 1 = positive above negative
  always @(posedge clk) begin
    n_q <= (want !== cmp_decision) ? n_q + 3'h1 : 3'h0;
    if (!slow || n_q == 3'h3)
      cmp_decision <= want;
  end
endmodule

// ==== verif/dcc_props.sv ====
// Port checker for the comparator control block
`timescale 1ns/10ps
module dcc_props (
  input wire logic clk,
  input wire logic rstn,
  input dcc_pkg::dcc_addr_t addr,
  input wire logic rd,
  input dcc_pkg::dcc_data_t rdata,
  input dcc_pkg::dcc_cmp_t port_f_direction,
  input wire logic sleep_active,
  input dcc_pkg::dcc_mode_t comparator_mode_field,
  input dcc_pkg::dcc_cmp_t cmp_power_on,
  input wire logic vref_to_positive,
  input wire logic negative_input_switch,
  input dcc_pkg::dcc_cmp_t pin_out,
  input dcc_pkg::dcc_cmp_t pin_oe,
  input wire logic irq_request,
  input wire logic wake_request
);
  import dcc_pkg::*;
  logic route;
  assign route = comparator_mode_field inside {3'h3, 3'h5};
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  AST_VREF: assert property (
    vref_to_positive == (comparator_mode_field == 3'h6))
    else $error("vref routing wrong");
  AST_SWITCH: assert property (
    negative_input_switch |-> comparator_mode_field == 3'h6)
    else $error("switch outside mode 6");
  AST_POWER: assert property (
    cmp_power_on == ((comparator_mode_field inside {3'h0, 3'h7}) ?
                     2'b00 : 2'b11))
    else $error("power decode wrong");
  AST_WAKE: assert property (
    wake_request == (sleep_active && irq_request))
    else $error("wake wrong");
  AST_OE: assert property (
    pin_oe == (route ? ~port_f_direction : 2'b00))
    else $error("pin enable wrong");
  AST_OUT: assert property (
    !route |-> pin_out == 2'b00) else $error("pin data outside routing");
  AST_RDMODE: assert property (
    rd && addr == 4'h0 |=> rdata[2:0] == $past(comparator_mode_field))
    else $error("mode readback wrong");
  AST_UNPOW: assert property (
    rd && addr == 4'h0 && !cmp_power_on[0] && !$past(cmp_power_on[0])
    |=> rdata[7:6] == 2'b00)
    else $error("status set while off");
  AST_IRQ: assert property (
    rd && addr == 4'h1 |=> (&rdata[3:0]) == $past(irq_request))
    else $error("request gating wrong");
  AST_PORT: assert property (
    rd && addr == 4'h2 && comparator_mode_field == 3'h0 |=> rdata == 8'h00)
    else $error("analog pins not zero");
  AST_RST: assert property (
    $rose(rstn) |-> comparator_mode_field == 3'h0 && cmp_power_on == 2'b00)
    else $error("reset state wrong");
endmodule

// ==== verif/dcc_top_test.sv ====
// Self-checking bench for the comparator control block
`timescale 1ns/10ps
`include "dcc_defs.svh"
module dcc_top_test;
  import dcc_pkg::*;
  logic clk, rstn, wr, rd, sleep_active, slow, rd_d, irq_request;
  logic vref_to_positive, negative_input_switch, wake_request;
  dcc_addr_t addr;
  dcc_data_t wdata, rdata, exp_q[$];
  dcc_cmp_t want, cmp_decision, port_f_direction, pin_out, pin_oe, pwr;
  dcc_pins_t pins, pin_level;
  dcc_mode_t comparator_mode_field;
  int n_fail, n_tests;
  logic [31:0] r;
  dcc_top u_dcc_top (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .cmp_decision(cmp_decision),
    .port_f_direction(port_f_direction), .pin_level(pin_level),
    .sleep_active(sleep_active), .comparator_mode_field(comparator_mode_field),
    .cmp_power_on(pwr), .vref_to_positive(vref_to_positive),
    .negative_input_switch(negative_input_switch), .pin_out(pin_out),
    .pin_oe(pin_oe), .irq_request(irq_request), .wake_request(wake_request));
  dcc_cmp_model u_dcc_cmp_model (.clk(clk), .want(want), .slow(slow),
    .pins(pins), .cmp_decision(cmp_decision), .pin_level(pin_level));
  function automatic logic [31:0] lfsr(logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic dcc_pins_t mask(int m);
    case (m[2:0])
      3'h3, 3'h4, 3'h5: return `DCC_MASK_ROUTED;
      3'h6: return m[3] ? `DCC_MASK_VREF_ALT : `DCC_MASK_VREF_PRI;
      3'h7: return `DCC_MASK_NONE;
      default: return `DCC_MASK_ALL;
    endcase
  endfunction
  task check(dcc_data_t got, dcc_data_t exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr_reg(dcc_addr_t a, dcc_data_t d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task rd_reg(dcc_addr_t a, dcc_data_t d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    exp_q.push_back(d);
    @(posedge clk);
    rd <= 1'b0;
  endtask
  task stop_test;
    $display("n_tests=%0d n_fail=%0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    if (rd_d)
      check(rdata, exp_q.pop_front());
    rd_d <= rd;
  end
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    repeat (3000) @(posedge clk);
    n_fail++;
    stop_test;
  end
  initial begin
    {rstn, wr, rd, sleep_active, slow} = '0;
    {addr, wdata, want, port_f_direction} = '0;
    pins = 6'h3f;
    r = 32'hcd73;
    {n_fail, n_tests} = '0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    rd_reg(4'h0, 8'h00);
    wr_reg(4'h0, 8'hff);
    rd_reg(4'h0, 8'h3f);
    check(8'(pwr), 8'h00);
    // Enables stay off while the mode moves
    for (int m = 0; m < 16; m++) begin
      r = lfsr(r);
      pins <= r[5:0];
      wr_reg(4'h0, 8'(m));
      check(8'(comparator_mode_field), 8'(m[2:0]));
      check(8'(negative_input_switch), 8'(m == 14));
      rd_reg(4'h2, {2'b00, r[5:0] & ~mask(m)});
    end
    wr_reg(4'h0, 8'h01);
    slow <= 1'b1;
    want <= 2'b01;
    repeat (12) @(posedge clk);
    // Mismatch still pending, so the clear is overridden
    wr_reg(4'h1, 8'h00);
    rd_reg(4'h1, 8'h01);
    rd_reg(4'h0, 8'h41);
    wr_reg(4'h1, 8'h00);
    rd_reg(4'h1, 8'h00);
    wr_reg(4'h0, 8'h31);
    repeat (4) @(posedge clk);
    rd_reg(4'h0, 8'hb1);
    sleep_active <= 1'b1;
    for (int e = 0; e < 8; e++) begin
      wr_reg(4'h1, 8'((e << 1) | 1));
      check(8'(irq_request), 8'(e == 7));
      check(8'(wake_request), 8'(e == 7));
    end
    sleep_active <= 1'b0;
    rd_reg(4'h0, 8'hb1);
    wr_reg(4'h0, 8'h13);
    slow <= 1'b0;
    repeat (6) begin
      r = lfsr(r);
      port_f_direction <= r[1:0];
      want <= r[3:2];
      @(posedge clk);
      #1;
      check(8'(pin_oe), 8'(~r[1:0] & 2'h3));
      check(8'(pin_out), 8'(r[3:2] ^ 2'h1));
    end
    @(posedge clk);
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    rd_reg(4'h0, 8'h00);
    repeat (3) @(posedge clk);
    stop_test;
  end
endmodule
bind dcc_top dcc_props u_dcc_props (.clk(clk), .rstn(rstn), .addr(addr),
  .rd(rd), .rdata(rdata), .port_f_direction(port_f_direction),
  .sleep_active(sleep_active), .comparator_mode_field(comparator_mode_field),
  .cmp_power_on(cmp_power_on), .vref_to_positive(vref_to_positive),
  .negative_input_switch(negative_input_switch), .pin_out(pin_out),
  .pin_oe(pin_oe), .irq_request(irq_request), .wake_request(wake_request));
